// ==== logic/tgn_pkg.sv ====
// Constants, types and register map of the task gate nesting control block
`default_nettype none
package tgn_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int SEL_W = 16;
    localparam int PL_W = 2;
    localparam int CNT_W = 16;
    localparam int CAUSE_W = 3;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] FCNT_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] SCNT_OFS = 4'hC;
    // Field positions
    localparam int CTRL_LONG_BIT = 0;
    localparam int STAT_FAULT_BIT = 0;
    localparam int STAT_SWITCH_BIT = 1;
    localparam int STAT_CAUSE_LSB = 4;
    // Busy bit in the descriptor word at byte offset +4
    localparam int DESC_HI_OFS = 4;
    localparam int BUSY_BIT = 9;
    localparam logic [DATA_W-1:0] BUSY_MASK = 32'h0000_0200;
    localparam logic CTRL_RST = 1'b0;

    typedef enum logic [2:0] {
        TGN_JUMP = 3'b000,
        TGN_CALL = 3'b001,
        TGN_SWINT = 3'b010,
        TGN_HWINT = 3'b011,
        TGN_EXC = 3'b100,
        TGN_INTERRUPT_RETURN_INSTRUCTION = 3'b101
    } tgn_init_e;

    typedef enum logic [CAUSE_W-1:0] {
        TGN_OK = 3'b000,
        TGN_LONG = 3'b001,
        TGN_GATE_CPL = 3'b010,
        TGN_GATE_RPL = 3'b011,
        TGN_DESC_PL = 3'b100,
        TGN_BUSY = 3'b101
    } tgn_cause_e;

    typedef struct packed {
        logic valid;
        tgn_init_e initiator;
        logic via_gate;
        logic [PL_W-1:0] current_privilege_level;
        logic [PL_W-1:0] requested_privilege_level;
        logic [PL_W-1:0] gate_descriptor_privilege;
        logic [PL_W-1:0] task_descriptor_privilege;
        logic nested_task_flag;
        logic [SEL_W-1:0] cur_link;
        logic [SEL_W-1:0] out_sel;
        logic [SEL_W-1:0] in_sel;
        logic [DATA_W-1:0] out_desc_hi;
        logic [DATA_W-1:0] in_desc_hi;
    } tgn_req_s;

    typedef struct packed {
        logic valid;
        logic fault;
        logic switched;
        tgn_cause_e cause;
        logic [SEL_W-1:0] target_sel;
        logic in_nt_set;
        logic in_link_wr;
        logic [SEL_W-1:0] in_link;
        logic out_nt_clr;
        logic out_desc_wr;
        logic [DATA_W-1:0] out_desc_hi;
        logic in_desc_wr;
        logic [DATA_W-1:0] in_desc_hi;
    } tgn_res_s;
endpackage
`default_nettype wire

// ==== logic/tgn_task_gate_ctrl.sv ====
// Task switch privilege, nesting and busy bit control
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Through a task gate, current privilege must not exceed gate's
// - Through a task gate, selector privilege must not exceed gate's
// - Task gate switches ignore the target task descriptor privilege
// - Failing either gate check alone denies the switch
// - Task gate use in long mode raises a protection fault
// - Jumps leave nested flag and link field untouched
// - Nesting initiators set incoming nested flag, store outgoing selector
// - Return switches only with nested flag set, target from link
// - Interrupt return switch clears outgoing nested flag
// - Busy bit is bit 9 of descriptor word at offset +4
// - Jump clears outgoing busy and sets incoming busy
// - Jump to an already busy task faults
// - Nesting initiators set incoming busy, outgoing busy stays set
// - Nesting initiators fault on an already busy target
// - Interrupt return clears outgoing busy, leaves incoming busy alone
// - Nested flag use by interrupt return has no privilege restriction
// - Failed check aborts without state change and raises fault
// - Interrupts and exceptions skip gate privilege checks
module tgn_task_gate_ctrl
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire tgn_pkg::tgn_req_s req_i,
    output tgn_pkg::tgn_res_s res_o,
    output logic long_mode_o,
    input wire logic [tgn_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [tgn_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [tgn_pkg::DATA_W-1:0] reg_rdata_o
);
    import tgn_pkg::*;

    // ------------------------------------------------------------
    // Initiator decode
    // ------------------------------------------------------------
    wire logic is_jump = req_i.initiator == TGN_JUMP;
    wire logic is_call = req_i.initiator == TGN_CALL;
    wire logic is_interrupt_return_instruction = req_i.initiator == TGN_INTERRUPT_RETURN_INSTRUCTION;
    wire logic is_nest = is_call || req_i.initiator == TGN_SWINT ||
        req_i.initiator == TGN_HWINT || req_i.initiator == TGN_EXC;
    wire logic is_branch = is_jump || is_call;

    logic long_mode_reg;

    // ------------------------------------------------------------
    // Checks, all evaluated before any write
    // ------------------------------------------------------------
    // Interrupt return only switches with nested flag set, any privilege
    wire logic sw_try = req_i.valid && (is_jump || is_nest ||
        (is_interrupt_return_instruction && req_i.nested_task_flag));
    wire logic long_bad = req_i.via_gate && long_mode_reg && !is_interrupt_return_instruction;
    wire logic gate_chk = is_branch && req_i.via_gate;
    wire logic gate_cpl_bad = gate_chk && (req_i.current_privilege_level >
        req_i.gate_descriptor_privilege);
    wire logic gate_rpl_bad = gate_chk && (req_i.requested_privilege_level >
        req_i.gate_descriptor_privilege);
    // Descriptor privilege only used when no gate is involved
    wire logic desc_bad = is_branch && !req_i.via_gate &&
        ((req_i.current_privilege_level > req_i.task_descriptor_privilege) ||
        (req_i.requested_privilege_level >
        req_i.task_descriptor_privilege));
    wire logic in_busy = req_i.in_desc_hi[BUSY_BIT];
    wire logic busy_bad = (is_jump || is_nest) && in_busy;

    wire tgn_cause_e cause = long_bad ? TGN_LONG :
        gate_cpl_bad ? TGN_GATE_CPL :
        gate_rpl_bad ? TGN_GATE_RPL :
        desc_bad ? TGN_DESC_PL :
        busy_bad ? TGN_BUSY : TGN_OK;
    wire logic fault = sw_try && cause != TGN_OK;
    wire logic ok = sw_try && cause == TGN_OK;

    // ------------------------------------------------------------
    // Result build
    // ------------------------------------------------------------
    tgn_res_s res_next;
    tgn_res_s res_reg;

    always_comb
    begin
        res_next = '0;
        res_next.valid = req_i.valid;
        res_next.fault = fault;
        res_next.switched = ok;
        res_next.cause = fault ? cause : TGN_OK;
        res_next.target_sel = is_interrupt_return_instruction ? req_i.cur_link : req_i.in_sel;
        res_next.in_link = req_i.out_sel;
        res_next.out_desc_hi = req_i.out_desc_hi & ~BUSY_MASK;
        res_next.in_desc_hi = req_i.in_desc_hi | BUSY_MASK;
        if (ok)
        begin
            res_next.in_nt_set = is_nest;
            res_next.in_link_wr = is_nest;
            res_next.out_nt_clr = is_interrupt_return_instruction;
            res_next.out_desc_wr = is_jump || is_interrupt_return_instruction;
            res_next.in_desc_wr = is_jump || is_nest;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            res_reg <= '0;
        else
            res_reg <= res_next;
    end

    assign res_o = res_reg;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic fault_sticky_reg;
    logic fault_sticky_next;
    logic [CAUSE_W-1:0] last_cause_reg;
    logic switch_seen_reg;
    logic [CNT_W-1:0] fault_cnt_reg;
    logic [CNT_W-1:0] switch_cnt_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    wire logic wr_ctrl = reg_wr_i && reg_addr_i == CTRL_OFS;
    wire logic wr_stat = reg_wr_i && reg_addr_i == STAT_OFS;
    wire logic fault_clr = wr_stat && reg_wdata_i[STAT_FAULT_BIT];
    wire logic [DATA_W-1:0] ctrl_val =
        {{(DATA_W-1){1'b0}}, long_mode_reg} << CTRL_LONG_BIT;
    wire logic [DATA_W-1:0] stat_val =
        ({{(DATA_W-1){1'b0}}, fault_sticky_reg} << STAT_FAULT_BIT) |
        ({{(DATA_W-1){1'b0}}, switch_seen_reg} << STAT_SWITCH_BIT) |
        ({{(DATA_W-CAUSE_W){1'b0}}, last_cause_reg} << STAT_CAUSE_LSB);
    wire logic [DATA_W-1:0] sel_val =
        reg_addr_i == CTRL_OFS ? ctrl_val :
        reg_addr_i == STAT_OFS ? stat_val :
        reg_addr_i == FCNT_OFS ? {{(DATA_W-CNT_W){1'b0}}, fault_cnt_reg} :
        reg_addr_i == SCNT_OFS ? {{(DATA_W-CNT_W){1'b0}}, switch_cnt_reg} :
        '0;

    // Set wins over a clear in the same cycle
    assign fault_sticky_next = fault || (fault_sticky_reg && !fault_clr);
    assign rdata_next = reg_rd_i ? sel_val : '0;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            long_mode_reg <= CTRL_RST;
            fault_sticky_reg <= 1'b0;
            last_cause_reg <= '0;
            switch_seen_reg <= 1'b0;
            fault_cnt_reg <= '0;
            switch_cnt_reg <= '0;
            rdata_reg <= '0;
        end
        else
        begin
            if (wr_ctrl)
                long_mode_reg <= reg_wdata_i[CTRL_LONG_BIT];
            fault_sticky_reg <= fault_sticky_next;
            if (fault)
                last_cause_reg <= cause;
            if (sw_try)
                switch_seen_reg <= ok;
            if (fault)
                fault_cnt_reg <= fault_cnt_reg + 1'b1;
            if (ok)
                switch_cnt_reg <= switch_cnt_reg + 1'b1;
            rdata_reg <= rdata_next;
        end
    end

    assign long_mode_o = long_mode_reg;
    assign reg_rdata_o = rdata_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_gate_cpl_check: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && gate_chk && req_i.current_privilege_level >
        req_i.gate_descriptor_privilege) |=> (res_o.fault && !res_o.switched))
        else $error("gate privilege violation not faulted");

    a_gate_rpl_check: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && gate_chk && !long_bad &&
        req_i.requested_privilege_level > req_i.gate_descriptor_privilege)
        |=> res_o.fault)
        else $error("selector privilege violation not faulted");

    a_gate_skip_desc: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && gate_chk && !long_bad && !in_busy &&
        req_i.current_privilege_level <= req_i.gate_descriptor_privilege &&
        req_i.requested_privilege_level <= req_i.gate_descriptor_privilege)
        |=> res_o.switched)
        else $error("gate switch wrongly denied");

    a_long_gate: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && !is_interrupt_return_instruction && req_i.via_gate && long_mode_reg)
        |=> (res_o.fault && res_o.cause == TGN_LONG))
        else $error("long mode gate not faulted");

    a_jump_no_nest: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (res_o.switched && $past(is_jump)) |->
        (!res_o.in_nt_set && !res_o.in_link_wr && res_o.out_desc_wr &&
        !res_o.out_desc_hi[BUSY_BIT] && res_o.in_desc_hi[BUSY_BIT]))
        else $error("jump nesting or busy update wrong");

    a_nest_link: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (res_o.switched && $past(is_nest)) |->
        (res_o.in_nt_set && res_o.in_link_wr && !res_o.out_desc_wr &&
        res_o.in_link == $past(req_i.out_sel)))
        else $error("nesting link update wrong");

    a_interrupt_return_instruction_nt_gate: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && is_interrupt_return_instruction && !req_i.nested_task_flag)
        |=> (!res_o.switched && !res_o.fault))
        else $error("return without nested flag switched");

    a_interrupt_return_instruction_switch: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && is_interrupt_return_instruction && req_i.nested_task_flag) |=>
        (res_o.switched && res_o.out_nt_clr && !res_o.in_desc_wr &&
        res_o.target_sel == $past(req_i.cur_link)))
        else $error("return switch effects wrong");

    a_busy_target: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && !is_interrupt_return_instruction && req_i.in_desc_hi[BUSY_BIT])
        |=> res_o.fault)
        else $error("busy target not faulted");

    a_fault_no_write: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        res_o.fault |-> !(res_o.in_nt_set || res_o.in_link_wr ||
        res_o.out_nt_clr || res_o.out_desc_wr || res_o.in_desc_wr))
        else $error("state written on fault");

    a_int_no_gate_pl: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && is_nest && !is_call && !long_bad && !in_busy)
        |=> res_o.switched)
        else $error("interrupt switch denied on privilege");

    a_one_check_deny: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && gate_chk &&
        ((req_i.current_privilege_level > req_i.gate_descriptor_privilege) !=
        (req_i.requested_privilege_level > req_i.gate_descriptor_privilege)))
        |=> (res_o.fault && !res_o.switched))
        else $error("single failed gate check not denied");

    a_busy_bit_pos: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        res_o.valid |-> (res_o.in_desc_hi[BUSY_BIT] &&
        !res_o.out_desc_hi[BUSY_BIT] && res_o.out_desc_hi[BUSY_BIT-1:0] ==
        $past(req_i.out_desc_hi[BUSY_BIT-1:0])))
        else $error("busy bit position wrong");

    a_jump_busy_flt: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && is_jump && req_i.in_desc_hi[BUSY_BIT])
        |=> (res_o.fault && !res_o.in_desc_wr && !res_o.out_desc_wr))
        else $error("jump to busy task not faulted");

    a_nest_busy_keep: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (res_o.switched && $past(is_nest)) |-> (res_o.in_desc_wr &&
        res_o.in_desc_hi[BUSY_BIT] && !res_o.out_desc_wr))
        else $error("nesting busy update wrong");

    a_interrupt_return_instruction_busy_clr: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (res_o.switched && $past(is_interrupt_return_instruction)) |-> (res_o.out_desc_wr &&
        !res_o.out_desc_hi[BUSY_BIT] && !res_o.in_desc_wr))
        else $error("return busy update wrong");

    a_interrupt_return_instruction_any_pl: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && is_interrupt_return_instruction && req_i.nested_task_flag)
        |=> (!res_o.fault && res_o.cause == TGN_OK))
        else $error("return refused on privilege");

    a_result_valid: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        res_o.valid == $past(req_i.valid))
        else $error("result valid not one cycle after request");

    a_fault_cause: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        res_o.valid |-> (res_o.fault == (res_o.cause != TGN_OK)))
        else $error("fault and cause disagree");

    a_switch_writes: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        res_o.switched |-> (!res_o.fault &&
        (res_o.in_desc_wr || res_o.out_desc_wr)))
        else $error("switch without busy update");
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking testbench for the task gate nesting control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import tgn_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    tgn_req_s req_i = '0;
    tgn_res_s res_o;
    logic long_mode_o;
    logic [ADDR_W-1:0] reg_addr_i = '0;
    logic [DATA_W-1:0] reg_wdata_i = '0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [DATA_W-1:0] reg_rdata_o;
    tgn_res_s exp_q[$];
    logic prev_rst = 1'b1;
    logic lm = 1'b0;
    int mismatches = 0;
    int n_checks = 0;
    int nfault = 0;
    int nsw = 0;
    logic sticky = 1'b0;
    logic lsw = 1'b0;
    logic [CAUSE_W-1:0] lcause = '0;
    logic [DATA_W-1:0] v;
    logic [127:0] raw;
    tgn_req_s r;

    tgn_task_gate_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .req_i(req_i), .res_o(res_o), .long_mode_o(long_mode_o),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

    always #2 clk_i = ~clk_i;

    // ----------------------------------------
    // Reference model and checks
    // ----------------------------------------
    function automatic tgn_res_s model(input tgn_req_s q, input logic l);
        tgn_res_s e;
        logic jc;
        logic nest;
        logic interrupt_return_instruction;
        logic ok;
        e = '0;
        jc = q.initiator inside {TGN_JUMP, TGN_CALL};
        nest = q.initiator inside {TGN_CALL, TGN_SWINT, TGN_HWINT, TGN_EXC};
        interrupt_return_instruction = q.initiator == TGN_INTERRUPT_RETURN_INSTRUCTION;
        e.valid = 1'b1;
        e.cause = TGN_OK;
        if (q.via_gate && l && !interrupt_return_instruction)
            e.cause = TGN_LONG;
        else if (jc && q.via_gate && q.current_privilege_level >
                 q.gate_descriptor_privilege)
            e.cause = TGN_GATE_CPL;
        else if (jc && q.via_gate && q.requested_privilege_level >
                 q.gate_descriptor_privilege)
            e.cause = TGN_GATE_RPL;
        else if (jc && !q.via_gate && (q.current_privilege_level >
                 q.task_descriptor_privilege || q.requested_privilege_level >
                 q.task_descriptor_privilege))
            e.cause = TGN_DESC_PL;
        else if (!interrupt_return_instruction && q.in_desc_hi[BUSY_BIT])
            e.cause = TGN_BUSY;
        e.fault = e.cause != TGN_OK;
        ok = !e.fault && (!interrupt_return_instruction || q.nested_task_flag);
        e.switched = ok;
        e.target_sel = interrupt_return_instruction ? q.cur_link : q.in_sel;
        e.in_link = q.out_sel;
        e.out_desc_hi = q.out_desc_hi & ~BUSY_MASK;
        e.in_desc_hi = q.in_desc_hi | BUSY_MASK;
        e.in_nt_set = ok && nest;
        e.in_link_wr = ok && nest;
        e.in_desc_wr = ok && !interrupt_return_instruction;
        e.out_desc_wr = ok && (interrupt_return_instruction || q.initiator == TGN_JUMP);
        e.out_nt_clr = ok && interrupt_return_instruction;
        return e;
    endfunction

    task automatic chk(input string nm, input logic [127:0] e,
                       input logic [127:0] g);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [SEL_W+2:0] nb(input tgn_res_s r);
        return {r.in_nt_set, r.in_link_wr, r.out_nt_clr, r.in_link};
    endfunction

    function automatic logic [3:0] bb(input tgn_res_s r);
        return {r.out_desc_wr, r.in_desc_wr, r.out_desc_hi[BUSY_BIT],
                r.in_desc_hi[BUSY_BIT]};
    endfunction

    task automatic check_res(input tgn_res_s x);
        chk("res_o", 128'(x), 128'(res_o));
        chk("fault", 128'(x.fault), 128'(res_o.fault));
        chk("switched", 128'(x.switched), 128'(res_o.switched));
        chk("cause", 128'(x.cause), 128'(res_o.cause));
        chk("target", 128'(x.target_sel), 128'(res_o.target_sel));
        chk("nest", 128'(nb(x)), 128'(nb(res_o)));
        chk("busy", 128'(bb(x)), 128'(bb(res_o)));
        if (x.fault)
        begin
            nfault++;
            sticky = 1'b1;
            lcause = x.cause;
        end
        if (x.fault || x.switched)
            lsw = x.switched;
        if (x.switched)
            nsw++;
    endtask

    always @(posedge clk_i)
    begin
        prev_rst <= sys_rst_i;
        if (req_i.valid === 1'b1 && sys_rst_i === 1'b0)
            exp_q.push_back(model(req_i, lm));
    end

    always @(negedge clk_i)
    begin
        if (exp_q.size() > 0)
            check_res(exp_q.pop_front());
        else if (!prev_rst)
            chk("res_o.valid", 128'(1'b0), 128'(res_o.valid));
    end

    // ----------------------------------------
    // Bus and request tasks
    // ----------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    task automatic send(input tgn_req_s q);
        @(posedge clk_i);
        req_i <= q;
    endtask

    task automatic idle();
        @(posedge clk_i);
        req_i <= '0;
        repeat (3) @(posedge clk_i);
    endtask

    function automatic tgn_req_s mk(input tgn_init_e i, input logic g,
        input logic [7:0] pl, input logic nt, input logic busy);
        tgn_req_s q;
        q = '0;
        q.valid = 1'b1;
        q.initiator = i;
        q.via_gate = g;
        {q.current_privilege_level, q.requested_privilege_level,
         q.gate_descriptor_privilege, q.task_descriptor_privilege} = pl;
        q.nested_task_flag = nt;
        q.cur_link = 16'h00A8;
        q.out_sel = 16'h0030;
        q.in_sel = 16'h0058;
        q.out_desc_hi = 32'h0000_8B00;
        q.in_desc_hi = busy ? 32'h0000_8B00 : 32'h0000_8900;
        return q;
    endfunction

    task automatic rand_batch(input int n);
        repeat (n)
        begin
            raw = {$urandom(), $urandom(), $urandom(), $urandom()};
            r = raw[$bits(tgn_req_s)-1:0];
            r.valid = 1'b1;
            r.initiator = tgn_init_e'(3'($urandom_range(5)));
            send(r);
        end
        idle();
    endtask

    task automatic counters();
        rd(FCNT_OFS, v);
        chk("fault_count", 128'(nfault), 128'(v));
        rd(SCNT_OFS, v);
        chk("switch_count", 128'(nsw), 128'(v));
        rd(STAT_OFS, v);
        chk("stat_fault", 128'(sticky), 128'(v[STAT_FAULT_BIT]));
        chk("stat_switch", 128'(lsw), 128'(v[STAT_SWITCH_BIT]));
        chk("stat_cause", 128'(lcause), 128'(v[STAT_CAUSE_LSB +: CAUSE_W]));
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        #(4 * 20000);
        mismatches++;
        final_report();
    end

    initial
    begin
        v = $urandom(62580);
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(CTRL_OFS, v);
        chk("ctrl_reset", 128'(CTRL_RST), 128'(v));
        counters();
        wr(4'h2, 32'hFFFF_FFFF);
        rd(4'h2, v);
        chk("unmapped", 128'(0), 128'(v));
        send(mk(TGN_JUMP, 1'b1, 8'hAC, 1'b0, 1'b0));
        send(mk(TGN_CALL, 1'b1, 8'hC8, 1'b0, 1'b0));
        send(mk(TGN_CALL, 1'b1, 8'h38, 1'b0, 1'b0));
        send(mk(TGN_SWINT, 1'b1, 8'hF0, 1'b0, 1'b0));
        send(mk(TGN_HWINT, 1'b0, 8'hF0, 1'b0, 1'b0));
        send(mk(TGN_EXC, 1'b1, 8'hF0, 1'b0, 1'b0));
        send(mk(TGN_JUMP, 1'b0, 8'h40, 1'b0, 1'b0));
        send(mk(TGN_JUMP, 1'b0, 8'h00, 1'b1, 1'b1));
        send(mk(TGN_CALL, 1'b0, 8'h00, 1'b0, 1'b1));
        send(mk(TGN_INTERRUPT_RETURN_INSTRUCTION, 1'b0, 8'hF0, 1'b0, 1'b1));
        send(mk(TGN_INTERRUPT_RETURN_INSTRUCTION, 1'b1, 8'hFF, 1'b1, 1'b1));
        idle();
        rand_batch(200);
        counters();
        wr(STAT_OFS, 32'h0000_0001);
        sticky = 1'b0;
        rd(STAT_OFS, v);
        chk("stat_clear", 128'(0), 128'(v[STAT_FAULT_BIT]));
        wr(CTRL_OFS, 32'h0000_0001);
        lm = 1'b1;
        rd(CTRL_OFS, v);
        chk("ctrl", 128'(1), 128'(v));
        chk("long_mode_o", 128'(1), 128'(long_mode_o));
        send(mk(TGN_JUMP, 1'b1, 8'h00, 1'b0, 1'b0));
        send(mk(TGN_INTERRUPT_RETURN_INSTRUCTION, 1'b1, 8'h00, 1'b1, 1'b0));
        rand_batch(150);
        counters();
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        nfault = 0;
        nsw = 0;
        sticky = 1'b0;
        lsw = 1'b0;
        lcause = '0;
        lm = 1'b0;
        counters();
        chk("long_mode_rst", 128'(CTRL_RST), 128'(long_mode_o));
        final_report();
    end
endmodule
`default_nettype wire
